/* File: design/sfc_pkg.sv */
// Shared constants and types for the serial flow control block
package sfc_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int DEFAULT_BAUD = 600;
   localparam int BAUD_W = 24;
   localparam logic [BAUD_W-1:0] DEFAULT_BAUD_DIV = BAUD_W'(CLK_HZ / DEFAULT_BAUD);
   localparam int MASTER_WAIT_S = 10;
   localparam int MASTER_WAIT_CYCLES = MASTER_WAIT_S * CLK_HZ;
   localparam int WAIT_W = 30;

   // ------------------------------------------------------------
   // Characters and framing
   // ------------------------------------------------------------
   localparam int CHAR_W = 8;
   localparam int FRAME_W = 10;
   localparam int BIT_CNT_W = 4;
   localparam int FIFO_DEPTH = 8;
   localparam logic [CHAR_W-1:0] XOFF_CODE = 8'h13;
   localparam logic [CHAR_W-1:0] XON_CODE = 8'h11;
   localparam logic [CHAR_W-1:0] CODE_MASK = 8'h7F;
   localparam logic MARK = 1'b1;
   localparam logic SPACE = 1'b0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WAIT_CTS = 2'h1,
      ST_SHIFT = 2'h3
   } sfc_tx_state_t;

   typedef enum logic [1:0] {
      PAR_NONE = 2'h0,
      PAR_EVEN = 2'h1,
      PAR_ODD = 2'h2
   } sfc_parity_t;

   typedef struct packed {
      logic [BAUD_W-1:0] baud_div;
      logic lcc_en;
      logic [3:0] addr_chars;
      sfc_parity_t parity;
      logic crc_en;
   } sfc_link_cfg_t;

   localparam sfc_link_cfg_t DEFAULT_LINK_CFG = '{
      baud_div: DEFAULT_BAUD_DIV,
      lcc_en: 1'b0,
      addr_chars: 4'h0,
      parity: PAR_EVEN,
      crc_en: 1'b0
   };

   // Parity bit is ignored when spotting a flow character
   function automatic logic sfc_is_code(logic [CHAR_W-1:0] c, logic [CHAR_W-1:0] code);
      return (c & CODE_MASK) == code;
   endfunction : sfc_is_code

endpackage : sfc_pkg

/* File: design/sfc_stream_if.sv */
// Valid/ready byte stream carried between the block's own modules
`timescale 1ns/1ps
interface sfc_stream_if #(parameter int W = 8) ();
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : sfc_stream_if

/* File: design/sfc_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sfc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Streams
   sfc_stream_if.snk in_s,
   sfc_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } sfc_fifo_state_t;

   sfc_fifo_state_t r;
   sfc_fifo_state_t next_r;
   logic push;
   logic pop;

   // Pointer wrap works for any depth, not only powers of two
   function automatic logic [AW-1:0] inc(logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : inc

   // ------------------------------------------------------------
   // Handshakes
   // ------------------------------------------------------------
   assign in_s.ready = (r.count != (AW + 1)'(DEPTH));
   assign out_s.valid = (r.count != '0);
   assign out_s.data = r.mem[r.rd];
   assign push = in_s.valid & in_s.ready;
   assign pop = out_s.valid & out_s.ready;

   // Next state
   always_comb begin
      next_r = r;
      if (push) begin
         next_r.mem[r.wr] = in_s.data;
         next_r.wr = inc(r.wr);
      end
      if (pop) begin
         next_r.rd = inc(r.rd);
      end
      next_r.count = (AW + 1)'(r.count + push - pop);
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule : sfc_fifo

/* File: design/sfc_flow_ctrl.sv */
// Serial port transmit flow control: pause/resume characters, RTS/CTR and CTS
//
// Function
// - Obey received pause and resume characters except in multi-address mode
// - Pause stops data within sixteen characters
// - Paused port holds data output at mark
// - Only the resume character ends a pause
// - Master declares tributary failed after ten seconds
// - Own pause/resume sent only under clear-to-send
// - Power-up state is not paused
// - Multi-address mode ignores all flow control; the code keeps a pause already in force, and it still holds data
// - Flow output selectable as RTS or clear_to_receive
// - Hardware flow control overrides everything else
// - RTS may rise when data is queued
// - Transmit only after clear-to-send seen
// - RTS held until last bit sent
// - clear_to_receive asserted while able to accept
// - No clear-to-send: hold mark, wait forever
// - Clear-to-send drop: at most two characters
// - Power-up: RTS off, clear_to_receive on
// - Grounded configure pin: defaults, accept command
// - Release of configure pin adopts command
`timescale 1ns/1ps
module sfc_flow_ctrl #(
   parameter int DEPTH = sfc_pkg::FIFO_DEPTH,
   parameter int MASTER_WAIT = sfc_pkg::MASTER_WAIT_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Transmit data from the user
   input wire logic [sfc_pkg::CHAR_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Characters from the receiver, and filtered characters to the user
   input wire logic [sfc_pkg::CHAR_W-1:0] rx_char,
   input wire logic rx_char_valid,
   input wire logic rx_can_accept,
   output logic [sfc_pkg::CHAR_W-1:0] rx_out_data,
   output logic rx_out_valid,
   // Configuration levels
   input wire logic mode_rts,
   input wire logic multi_addr,
   input wire logic is_master,
   input wire logic gen_xoff,
   input wire logic gen_xon,
   // Link configuration
   input wire logic cfg_pin_n,
   input wire logic cmd_cfg_valid,
   input wire sfc_pkg::sfc_link_cfg_t cmd_cfg,
   input wire logic panel_cfg_load,
   input wire sfc_pkg::sfc_link_cfg_t panel_cfg,
   output sfc_pkg::sfc_link_cfg_t link_cfg,
   // Serial pins
   input wire logic cts_in,
   output logic txd,
   output logic flow_out,
   // Status
   output logic paused,
   output logic trib_fail
);
   localparam int CW = sfc_pkg::CHAR_W;
   localparam int BW = sfc_pkg::BAUD_W;
   localparam int NW = sfc_pkg::BIT_CNT_W;
   localparam int WW = sfc_pkg::WAIT_W;
   localparam logic [WW-1:0] WAIT_LAST = WW'(MASTER_WAIT - 1);

   typedef struct packed {
      sfc_pkg::sfc_tx_state_t st;
      logic [sfc_pkg::FRAME_W-1:0] shreg;
      logic [NW-1:0] bit_cnt;
      logic [BW-1:0] baud_cnt;
      logic is_data, paused, rts, ctr;
      logic pend_xon, pend_xoff;
      logic cts_s1, cts_s2;
      logic cfg_s1, cfg_s2, cfg_s3;
      sfc_pkg::sfc_link_cfg_t active;
      sfc_pkg::sfc_link_cfg_t staged;
      logic staged_ok;
      logic [WW-1:0] wait_cnt;
      logic trib_fail;
      logic [CW-1:0] rx_data;
      logic rx_valid;
   } sfc_state_t;

   localparam sfc_state_t RESET_STATE = '{
      st: sfc_pkg::ST_IDLE, shreg: '1, bit_cnt: '0, baud_cnt: '0, is_data: 1'b0,
      paused: 1'b0, rts: 1'b0, ctr: 1'b1, pend_xon: 1'b0, pend_xoff: 1'b0,
      cts_s1: 1'b0, cts_s2: 1'b0, cfg_s1: 1'b1, cfg_s2: 1'b1, cfg_s3: 1'b1,
      active: sfc_pkg::DEFAULT_LINK_CFG, staged: sfc_pkg::DEFAULT_LINK_CFG,
      staged_ok: 1'b0, wait_cnt: '0, trib_fail: 1'b0, rx_data: '0, rx_valid: 1'b0
   };

   sfc_state_t r;
   sfc_state_t next_r;

   sfc_stream_if #(.W(CW)) in_if ();
   sfc_stream_if #(.W(CW)) out_if ();

   logic hw_ok, xoff_hit, xon_hit, flow_pend;
   logic data_ok, want_tx, load, load_data, frame_done;

   // ------------------------------------------------------------
   // Transmit FIFO
   // ------------------------------------------------------------
   assign in_if.data = tx_data;
   assign in_if.valid = tx_valid;
   assign tx_ready = in_if.ready;
   assign out_if.ready = load_data;

   sfc_fifo #(.W(CW), .DEPTH(DEPTH)) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_s(in_if.snk),
      .out_s(out_if.src)
   );

   // ------------------------------------------------------------
   // Decisions
   // ------------------------------------------------------------
   // Multi-address links see CTS as always granted, no pause chars
   assign hw_ok = multi_addr | r.cts_s2;
   assign xoff_hit = rx_char_valid & !multi_addr
                     & sfc_pkg::sfc_is_code(rx_char, sfc_pkg::XOFF_CODE);
   assign xon_hit = rx_char_valid & !multi_addr
                    & sfc_pkg::sfc_is_code(rx_char, sfc_pkg::XON_CODE);
   assign flow_pend = (r.pend_xon | r.pend_xoff) & !multi_addr;
   assign data_ok = out_if.valid & !r.paused;
   assign want_tx = flow_pend | data_ok;
   // Start only from the wait state with CTS seen granted
   assign load = (r.st == sfc_pkg::ST_WAIT_CTS) & want_tx & hw_ok;
   assign load_data = load & !flow_pend & data_ok;
   assign frame_done = (r.st == sfc_pkg::ST_SHIFT) & (r.baud_cnt == '0)
                       & (r.bit_cnt == '0);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      // Pins pass two flops before anything looks at them
      next_r.cts_s1 = cts_in;
      next_r.cts_s2 = r.cts_s1;
      next_r.cfg_s1 = cfg_pin_n;
      next_r.cfg_s2 = r.cfg_s1;
      next_r.cfg_s3 = r.cfg_s2;

      // Pause state follows only the received flow characters
      if (xoff_hit) begin
         next_r.paused = 1'b1;
      end else if (xon_hit) begin
         next_r.paused = 1'b0;
      end

      // Requests to send own flow characters; a new request beats the clear
      next_r.pend_xoff = (r.pend_xoff & !(load & r.pend_xoff))
                         | (gen_xoff & !multi_addr);
      next_r.pend_xon = (r.pend_xon & !(load & !r.pend_xoff & r.pend_xon))
                        | (gen_xon & !multi_addr);

      // Transmitter; the character boundary is the only stop point, so
      // a pause or CTS drop costs at most the character in flight
      unique case (r.st)
         sfc_pkg::ST_IDLE: begin
            if (want_tx) begin
               next_r.st = sfc_pkg::ST_WAIT_CTS;
            end
         end
         sfc_pkg::ST_WAIT_CTS: begin
            // Data output stays at mark while waiting, without limit
            if (!want_tx) begin
               next_r.st = sfc_pkg::ST_IDLE;
            end else if (hw_ok) begin
               next_r.st = sfc_pkg::ST_SHIFT;
               next_r.bit_cnt = NW'(sfc_pkg::FRAME_W - 1);
               next_r.baud_cnt = BW'(r.active.baud_div - 1'b1);
               next_r.is_data = !flow_pend;
               if (r.pend_xoff & !multi_addr) begin
                  next_r.shreg = {sfc_pkg::MARK, sfc_pkg::XOFF_CODE, sfc_pkg::SPACE};
               end else if (r.pend_xon & !multi_addr) begin
                  next_r.shreg = {sfc_pkg::MARK, sfc_pkg::XON_CODE, sfc_pkg::SPACE};
               end else begin
                  next_r.shreg = {sfc_pkg::MARK, out_if.data, sfc_pkg::SPACE};
               end
            end
         end
         sfc_pkg::ST_SHIFT: begin
            if (r.baud_cnt != '0) begin
               next_r.baud_cnt = BW'(r.baud_cnt - 1'b1);
            end else if (r.bit_cnt == '0) begin
               next_r.st = sfc_pkg::ST_IDLE;
               next_r.shreg = '1;
            end else begin
               next_r.shreg = {sfc_pkg::MARK, r.shreg[sfc_pkg::FRAME_W-1:1]};
               next_r.bit_cnt = NW'(r.bit_cnt - 1'b1);
               next_r.baud_cnt = BW'(r.active.baud_div - 1'b1);
            end
         end
         default: begin
            next_r.st = sfc_pkg::ST_IDLE;
            next_r.shreg = '1;
         end
      endcase

      // RTS stays up across queued characters, drops after the stop bit
      next_r.rts = (next_r.st != sfc_pkg::ST_IDLE) | want_tx;
      next_r.ctr = rx_can_accept;

      // Only a master gives up on a paused partner, never a tributary
      if (r.paused & is_master) begin
         if (r.wait_cnt == WAIT_LAST) begin
            next_r.trib_fail = 1'b1;
         end else begin
            next_r.wait_cnt = WW'(r.wait_cnt + 1'b1);
         end
      end else begin
         next_r.wait_cnt = '0;
         next_r.trib_fail = 1'b0;
      end

      // Link configuration through the configure pin
      if (!r.cfg_s2) begin
         next_r.active = sfc_pkg::DEFAULT_LINK_CFG;
         if (cmd_cfg_valid) begin
            next_r.staged = cmd_cfg;
            next_r.staged_ok = 1'b1;
         end
      end else if (!r.cfg_s3 & r.staged_ok) begin
         next_r.active = r.staged;
         next_r.staged_ok = 1'b0;
      end else if (!r.cfg_s3 | panel_cfg_load) begin
         next_r.active = panel_cfg;
         next_r.staged_ok = 1'b0;
      end

      // Receive path swallows flow characters unless multi-address
      next_r.rx_valid = rx_char_valid & !xoff_hit & !xon_hit;
      if (rx_char_valid) begin
         next_r.rx_data = rx_char;
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r <= RESET_STATE;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Serial line idles at mark because the shifter refills with ones
   assign txd = r.shreg[0];
   assign flow_out = mode_rts ? r.rts : r.ctr;
   assign paused = r.paused;
   assign trib_fail = r.trib_fail;
   assign link_cfg = r.active;
   assign rx_out_data = r.rx_data;
   assign rx_out_valid = r.rx_valid;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_char_start;
      (r.st == sfc_pkg::ST_WAIT_CTS) ##1 (r.st == sfc_pkg::ST_SHIFT);
   endsequence

   sequence s_last_out;
      mode_rts && frame_done && !want_tx;
   endsequence

   a_start_granted: assert property (s_char_start |-> $past(hw_ok))
      else $error("character started without clear-to-send");

   a_no_data_paused: assert property (
      s_char_start |-> !($past(r.paused) && r.is_data))
      else $error("data character started while paused");

   a_mark_when_held: assert property (
      r.st != sfc_pkg::ST_SHIFT |-> txd)
      else $error("data output not at mark while held");

   a_rts_through_char: assert property (
      mode_rts && r.st == sfc_pkg::ST_SHIFT |-> flow_out)
      else $error("rts low during a character");

   a_rts_released: assert property (
      s_last_out ##1 mode_rts |-> !flow_out)
      else $error("rts not dropped after last bit");

   a_ctr_follows: assert property (
      !mode_rts && $past(rx_can_accept) |-> flow_out)
      else $error("clear_to_receive low while able to accept");

   a_xoff_pauses: assert property (xoff_hit |=> r.paused)
      else $error("pause character not obeyed");

   a_pause_ends_xon: assert property (
      r.paused ##1 !r.paused |-> $past(xon_hit))
      else $error("pause ended without resume character");

   a_multi_no_pause: assert property (
      multi_addr && !r.paused ##1 multi_addr |-> !r.paused)
      else $error("paused in multi-address mode");

   a_master_wait: assert property (
      $rose(r.trib_fail) |-> $past(r.wait_cnt) == WAIT_LAST && $past(is_master))
      else $error("tributary failure declared early");

   a_cfg_default: assert property (
      !r.cfg_s2 |=> link_cfg == sfc_pkg::DEFAULT_LINK_CFG)
      else $error("defaults not used while configure pin grounded");

   a_cfg_adopt: assert property (
      r.cfg_s2 && !r.cfg_s3 && r.staged_ok |=> link_cfg == $past(r.staged))
      else $error("command settings not adopted on release");

   a_reset_values: assert property (@(posedge core_clk) disable iff (1'b0)
      !rst_n |=> !r.paused && !r.rts && r.ctr)
      else $error("wrong flow state after reset");

endmodule : sfc_flow_ctrl

/* File: test/sfc_remote.sv */
// Far-end computer model: grants clear-to-send and decodes frames on txd
`timescale 1ns/1ps
module sfc_remote (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial lines
   input wire logic txd,
   output logic cts_in,
   // Control from the bench
   input wire logic cts_grant,
   input wire logic [sfc_pkg::BAUD_W-1:0] baud_div,
   // Decoded traffic
   output logic [sfc_pkg::CHAR_W-1:0] last_char,
   output int n_rx,
   output int n_ferr
);
   int cnt;
   int bitn;
   logic busy;

   // Grant is a plain level; the bench holds it high when it does not stall
   assign cts_in = cts_grant;

   // Mid-bit sampler, 8N1, LSB first; a bad start or stop bit is counted
   always @(posedge core_clk) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cnt <= 0;
         bitn <= 0;
         n_rx <= 0;
         n_ferr <= 0;
         last_char <= 8'h00;
      end else if (!busy) begin
         if (txd === 1'b0) begin
            busy <= 1'b1;
            bitn <= 0;
            cnt <= int'(baud_div) / 2;
         end
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         cnt <= int'(baud_div);
         bitn <= bitn + 1;
         if (bitn == 0 && txd !== 1'b0) n_ferr <= n_ferr + 1;
         if (bitn >= 1 && bitn <= 8) last_char <= {txd, last_char[7:1]};
         if (bitn == 9) begin
            busy <= 1'b0;
            n_rx <= n_rx + 1;
            if (txd !== 1'b1) n_ferr <= n_ferr + 1;
         end
      end
   end
endmodule : sfc_remote

/* File: test/serial_flow_control_test.sv */
// Self-checking bench for the serial flow control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      miscompares++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
   end end
module serial_flow_control_test;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int TB_WAIT = 20;
   logic core_clk, rst_n, tx_valid, tx_ready, rx_char_valid, rx_can_accept, rx_out_valid;
   logic mode_rts, multi_addr, is_master, gen_xoff, gen_xon, cfg_pin_n, cmd_cfg_valid;
   logic panel_cfg_load, cts_in, cts_grant, txd, flow_out, paused, trib_fail;
   logic [7:0] tx_data, rx_char, rx_out_data, last_char;
   sfc_pkg::sfc_link_cfg_t cmd_cfg, panel_cfg, link_cfg;
   int n_rx, n_ferr, nr, miscompares, compares;

   sfc_flow_ctrl #(.DEPTH(8), .MASTER_WAIT(TB_WAIT)) u_sfc_flow_ctrl (
      .core_clk(core_clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
      .rx_can_accept(rx_can_accept), .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid),
      .mode_rts(mode_rts), .multi_addr(multi_addr), .is_master(is_master),
      .gen_xoff(gen_xoff), .gen_xon(gen_xon), .cfg_pin_n(cfg_pin_n),
      .cmd_cfg_valid(cmd_cfg_valid), .cmd_cfg(cmd_cfg), .panel_cfg_load(panel_cfg_load),
      .panel_cfg(panel_cfg), .link_cfg(link_cfg), .cts_in(cts_in), .txd(txd),
      .flow_out(flow_out), .paused(paused), .trib_fail(trib_fail));

   sfc_remote u_sfc_remote (
      .core_clk(core_clk), .rst_n(rst_n), .txd(txd), .cts_in(cts_in), .cts_grant(cts_grant),
      .baud_div(link_cfg.baud_div), .last_char(last_char), .n_rx(n_rx), .n_ferr(n_ferr));

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // All drives land 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic push(input logic [7:0] c);
      tx_data = c;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) tick(1);
      tick(1);
      tx_valid = 1'b0;
      tick(1);
   endtask : push

   task automatic rx(input logic [7:0] c);
      rx_char = c;
      rx_char_valid = 1'b1;
      tick(1);
      rx_char_valid = 1'b0;
   endtask : rx

   // Counts cycles in which the line left mark
   task automatic hold_mark(input int n);
      int z;
      z = 0;
      repeat (n) begin
         tick(1);
         if (txd !== 1'b1) z++;
      end
      `CHK("txd_at_mark", 0, z)
   endtask : hold_mark

   // Bounded wait for the far end to decode one more frame
   task automatic wait_rx(input int n0);
      int k;
      k = 0;
      while (n_rx == n0 && k < 3000) begin
         tick(1);
         k++;
      end
      `CHK("frame_seen", n0 + 1, n_rx)
   endtask : wait_rx

   task automatic wait_start();
      int k;
      k = 0;
      while (txd !== 1'b0 && k < 200) begin
         tick(1);
         k++;
      end
   endtask : wait_start

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_power_up();
      `CHK("txd", 1'b1, txd)
      `CHK("paused", 1'b0, paused)
      `CHK("trib_fail", 1'b0, trib_fail)
      `CHK("tx_ready", 1'b1, tx_ready)
      `CHK("flow_out", 1'b1, flow_out)
      rx_can_accept = 1'b0;
      tick(2);
      `CHK("flow_out", 1'b0, flow_out)
      rx_can_accept = 1'b1;
      tick(2);
      `CHK("flow_out", 1'b1, flow_out)
      mode_rts = 1'b1;
      tick(2);
      `CHK("flow_out", 1'b0, flow_out)
   endtask : t_power_up

   task automatic t_link_config();
      cfg_pin_n = 1'b0;
      tick(4);
      `CHK("link_cfg", sfc_pkg::DEFAULT_LINK_CFG, link_cfg)
      cmd_cfg = '{24'h000008, 1'b1, 4'h2, sfc_pkg::PAR_ODD, 1'b1};
      cmd_cfg_valid = 1'b1;
      tick(1);
      cmd_cfg_valid = 1'b0;
      tick(3);
      `CHK("link_cfg", sfc_pkg::DEFAULT_LINK_CFG, link_cfg)
      cfg_pin_n = 1'b1;
      tick(4);
      `CHK("link_cfg", cmd_cfg, link_cfg)
      // Panel load after release; same bit time keeps later frames short
      panel_cfg = '{24'h000008, 1'b0, 4'h1, sfc_pkg::PAR_NONE, 1'b0};
      panel_cfg_load = 1'b1;
      tick(1);
      panel_cfg_load = 1'b0;
      `CHK("link_cfg", panel_cfg, link_cfg)
   endtask : t_link_config

   task automatic t_send_one();
      nr = n_rx;
      push(8'hA5);
      tick(2);
      `CHK("flow_out", 1'b1, flow_out)
      wait_rx(nr);
      `CHK("char", 8'hA5, last_char)
      `CHK("flow_out", 1'b1, flow_out)
      tick(12);
      `CHK("flow_out", 1'b0, flow_out)
   endtask : t_send_one

   // Clear-to-send withheld, granted, then dropped mid-character
   task automatic t_cts_gate();
      cts_grant = 1'b0;
      tick(3);
      nr = n_rx;
      push(8'hC3);
      push(8'h3C);
      hold_mark(50);
      `CHK("flow_out", 1'b1, flow_out)
      cts_grant = 1'b1;
      wait_start();
      cts_grant = 1'b0;
      wait_rx(nr);
      `CHK("char", 8'hC3, last_char)
      hold_mark(100);
      `CHK("frames", nr + 1, n_rx)
      cts_grant = 1'b1;
      wait_rx(nr + 1);
      `CHK("char", 8'h3C, last_char)
   endtask : t_cts_gate

   // Pause with parity bit set arrives mid-character on a master port,
   // then a paused tributary must never give up
   task automatic t_pause();
      is_master = 1'b1;
      nr = n_rx;
      push(8'h61);
      push(8'h62);
      wait_start();
      rx(8'h93);
      `CHK("paused", 1'b1, paused)
      `CHK("rx_out_valid", 1'b0, rx_out_valid)
      tick(10);
      `CHK("trib_fail", 1'b0, trib_fail)
      wait_rx(nr);
      `CHK("char", 8'h61, last_char)
      hold_mark(60);
      `CHK("trib_fail", 1'b1, trib_fail)
      rx(8'h41);
      `CHK("rx_out_data", 8'h41, rx_out_data)
      `CHK("paused", 1'b1, paused)
      hold_mark(30);
      rx(8'h91);
      `CHK("paused", 1'b0, paused)
      tick(1);
      `CHK("trib_fail", 1'b0, trib_fail)
      wait_rx(nr + 1);
      `CHK("char", 8'h62, last_char)
      is_master = 1'b0;
      rx(8'h13);
      hold_mark(40);
      `CHK("trib_fail", 1'b0, trib_fail)
      rx(8'h11);
   endtask : t_pause

   // Fill the FIFO while stalled, then drain it with one more stall
   task automatic t_fifo_fill();
      cts_grant = 1'b0;
      tick(3);
      nr = n_rx;
      for (int i = 0; i < 8; i++) push(8'h30 + 8'(i));
      `CHK("fifo_full", 1'b0, tx_ready)
      cts_grant = 1'b1;
      for (int i = 0; i < 8; i++) begin
         wait_rx(nr + i);
         `CHK("char", 8'h30 + 8'(i), last_char)
         if (i == 2) begin
            cts_grant = 1'b0;
            hold_mark(40);
            cts_grant = 1'b1;
         end
      end
      tick(12);
      `CHK("flow_out", 1'b0, flow_out)
   endtask : t_fifo_fill

   task automatic t_own_flow();
      nr = n_rx;
      gen_xoff = 1'b1;
      tick(1);
      gen_xoff = 1'b0;
      wait_rx(nr);
      `CHK("char", 8'h13, last_char)
      cts_grant = 1'b0;
      tick(3);
      gen_xon = 1'b1;
      tick(1);
      gen_xon = 1'b0;
      hold_mark(60);
      cts_grant = 1'b1;
      wait_rx(nr + 1);
      `CHK("char", 8'h11, last_char)
   endtask : t_own_flow

   task automatic t_multi_addr();
      multi_addr = 1'b1;
      cts_grant = 1'b0;
      tick(3);
      rx(8'h13);
      `CHK("rx_out_valid", 1'b1, rx_out_valid)
      `CHK("paused", 1'b0, paused)
      nr = n_rx;
      push(8'h77);
      wait_rx(nr);
      `CHK("char", 8'h77, last_char)
      tick(12);
      multi_addr = 1'b0;
      cts_grant = 1'b1;
   endtask : t_multi_addr

   // ------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ------------------------------------------------------------
   task automatic results();
      if (miscompares == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   // Whole run needs some 2000 cycles; a hang is cut at 30000
   initial begin
      repeat (30000) @(posedge core_clk);
      miscompares++;
      $display("[ERR] watchdog exp done got hang");
      results();
   end

   initial begin
      miscompares = 0;
      compares = 0;
      rst_n = 1'b0;
      {tx_valid, rx_char_valid, multi_addr, is_master, gen_xoff, gen_xon} = 6'h00;
      {mode_rts, cmd_cfg_valid, panel_cfg_load} = 3'h0;
      {rx_can_accept, cfg_pin_n, cts_grant} = 3'h7;
      tx_data = 8'h00;
      rx_char = 8'h00;
      cmd_cfg = sfc_pkg::DEFAULT_LINK_CFG;
      panel_cfg = sfc_pkg::DEFAULT_LINK_CFG;
      repeat (8) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      t_power_up();
      t_link_config();
      t_send_one();
      t_cts_gate();
      t_pause();
      t_fifo_fill();
      t_own_flow();
      t_multi_addr();
      `CHK("frame_errors", 0, n_ferr)
      results();
   end
endmodule : serial_flow_control_test
